// file: logic/rab_bank.sv
// Register bank showing the access kinds of peripheral registers
// Contract
// - Read/write bits return last written value
// - Read-only bits ignore writes, show state
// - Write-only bits act; read value is zero
// - Reserved bits always read as zero
// - Reset values on reset; debug survives soft reset
// - Base and companions read identical contents
// - Clear companion one clears base bit
// - Set companion one sets base bit
// - Toggle companion one inverts base bit
`timescale 1ns/1ps
module rab_bank (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire rab_pkg::rab_req_t req_in,
  input  wire logic [3:0]        status_in,
  output logic [7:0]             rdata_out,
  output logic                   rvalid_out,
  output logic [7:0]             base_out,
  output logic [5:0]             ctrl_out,
  output logic [2:0]             debug_out,
  output logic                   pulse_out
);
  import rab_pkg::*;

  logic [7:0] base_q;
  logic [7:0] ctrl_q;
  logic [7:0] debug_q;
  logic [3:0] status_meta;
  logic [3:0] status_sync;
  logic       swrst;
  logic       pair_wr;
  rab_op_t    pair_op;
  logic [7:0] next_rdata;

  // Decoding shared by the write path and the assertions
  function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
    return a == r;
  endfunction : hit

  function automatic logic is_pair(input logic [2:0] a);
    return hit(a, REG_BASE) | hit(a, REG_SET) | hit(a, REG_CLEAR) | hit(a, REG_TOGGLE);
  endfunction : is_pair

  assign swrst   = req_in.wr & hit(req_in.addr, REG_CMD) & req_in.wdata[CMD_SWRST_BIT];
  assign pair_wr = req_in.wr & is_pair(req_in.addr);

  always_comb begin
    unique case (req_in.addr[1:0])
      2'h1:    pair_op = RAB_OP_SET;
      2'h2:    pair_op = RAB_OP_CLEAR;
      2'h3:    pair_op = RAB_OP_TOGGLE;
      2'h0:    pair_op = RAB_OP_NONE;
    endcase
  end

  rab_pair_reg u_pair (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .swrst_in  (swrst),
    .wr_in     (pair_wr),
    .op_in     (pair_op),
    .wdata_in  (req_in.wdata),
    .value_out (base_q)
  );

  // Status pins come from outside this clock domain
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_meta <= 4'h0;
      status_sync <= 4'h0;
    end else begin
      status_meta <= status_in;
      status_sync <= status_meta;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q <= CTRL_RST;
    end else if (swrst) begin
      ctrl_q <= CTRL_RST;
    end else if (req_in.wr && hit(req_in.addr, REG_CTRL)) begin
      ctrl_q <= req_in.wdata & CTRL_MASK;
    end
  end

  // Debug control is kept across a soft reset so a debugger session survives
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      debug_q <= DEBUG_RST;
    end else if (req_in.wr && hit(req_in.addr, REG_DEBUG)) begin
      debug_q <= req_in.wdata & DEBUG_MASK;
    end
  end

  // Write-only command pulse
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= req_in.wr & hit(req_in.addr, REG_CMD) & req_in.wdata[CMD_PULSE_BIT];
    end
  end

  // Pulse lasts one cycle, only after a command write with its bit set
  a_pulse_fire: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.wr && hit(req_in.addr, REG_CMD) && req_in.wdata[CMD_PULSE_BIT]
    |=> pulse_out)
    else $error("command pulse missing");
  a_pulse_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !(req_in.wr && hit(req_in.addr, REG_CMD))
    |=> !pulse_out)
    else $error("command pulse without a command write");

  always_comb begin
    next_rdata = 8'h00;
    unique case (req_in.addr)
      REG_BASE, REG_SET, REG_CLEAR, REG_TOGGLE: next_rdata = base_q;
      REG_CTRL:   next_rdata = ctrl_q & CTRL_MASK;
      REG_STATUS: next_rdata = {4'h0, status_sync} & STATUS_MASK;
      REG_CMD:    next_rdata = 8'h00;
      REG_DEBUG:  next_rdata = debug_q & DEBUG_MASK;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out  <= 8'h00;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= req_in.rd;
      rdata_out  <= req_in.rd ? next_rdata : 8'h00;
    end
  end

  // Read answer stands exactly one cycle; idle cycles show zero data
  a_read_answer: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.rd |=> rvalid_out)
    else $error("read not answered");
  a_idle_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !req_in.rd |=> !rvalid_out && (rdata_out == 8'h00))
    else $error("read answer without a read");

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      base_out  <= BASE_RST;
      ctrl_out  <= CTRL_RST[5:0];
      debug_out <= DEBUG_RST[2:0];
    end else begin
      base_out  <= base_q;
      ctrl_out  <= ctrl_q[5:0];
      debug_out <= debug_q[2:0];
    end
  end

  // Companion writes; a soft reset never shares their cycle, it needs the command address
  a_set_effect: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.wr && hit(req_in.addr, REG_SET) |=> ((base_q & $past(req_in.wdata)) == $past(req_in.wdata)))
    else $error("set companion did not set bits");
  a_clear_effect: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.wr && hit(req_in.addr, REG_CLEAR) |=> ((base_q & $past(req_in.wdata)) == 8'h00))
    else $error("clear companion did not clear bits");
  a_toggle_effect: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.wr && hit(req_in.addr, REG_TOGGLE) |=> (base_q == ($past(base_q) ^ $past(req_in.wdata))))
    else $error("toggle companion did not invert bits");
  a_zero_keep: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.wr && (hit(req_in.addr, REG_SET) || hit(req_in.addr, REG_CLEAR) || hit(req_in.addr, REG_TOGGLE))
    |=> ((base_q & ~$past(req_in.wdata)) == ($past(base_q) & ~$past(req_in.wdata))))
    else $error("companion zero bits changed base");
  a_base_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.wr && hit(req_in.addr, REG_BASE) |=> base_q == $past(req_in.wdata))
    else $error("base write not taken");
  a_pair_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.rd && is_pair(req_in.addr) && !req_in.wr |=> rdata_out == base_q)
    else $error("pair read differs from base");
  // Two pair reads with no write between must agree, whichever members
  a_pair_same: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.rd && is_pair(req_in.addr) && !req_in.wr ##1 (req_in.rd && is_pair(req_in.addr) && !req_in.wr)
    |=> rdata_out == $past(rdata_out))
    else $error("pair members read differently");

  // Plain read/write registers
  a_ctrl_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.wr && hit(req_in.addr, REG_CTRL) |=> ctrl_q == ($past(req_in.wdata) & CTRL_MASK))
    else $error("control write not taken");
  a_rw_readback: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.wr && hit(req_in.addr, REG_CTRL) ##1 (req_in.rd && hit(req_in.addr, REG_CTRL) && !req_in.wr)
    |=> rdata_out == ($past(req_in.wdata, 2) & CTRL_MASK))
    else $error("control readback mismatch");
  a_debug_readback: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.wr && hit(req_in.addr, REG_DEBUG) ##1 (req_in.rd && hit(req_in.addr, REG_DEBUG) && !req_in.wr)
    |=> rdata_out == ($past(req_in.wdata, 2) & DEBUG_MASK))
    else $error("debug readback mismatch");

  // Reserved, read-only and write-only bits
  a_reserved_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.rd && hit(req_in.addr, REG_CTRL) |=> ((rdata_out & ~CTRL_MASK) == 8'h00))
    else $error("control reserved bits read nonzero");
  a_debug_reserved: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.rd && hit(req_in.addr, REG_DEBUG) |=> ((rdata_out & ~DEBUG_MASK) == 8'h00))
    else $error("debug reserved bits read nonzero");
  a_status_reserved: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.rd && hit(req_in.addr, REG_STATUS) |=> ((rdata_out & ~STATUS_MASK) == 8'h00))
    else $error("status reserved bits read nonzero");
  a_status_ro: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.rd && hit(req_in.addr, REG_STATUS) |=> rdata_out == {4'h0, $past(status_sync)})
    else $error("status read wrong");
  a_status_nowrite: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.wr && hit(req_in.addr, REG_STATUS) |=> $stable(base_q) && $stable(ctrl_q) && $stable(debug_q))
    else $error("status write changed a register");
  // Command bits have no storage, so a read shows nothing of them
  a_cmd_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    req_in.rd && hit(req_in.addr, REG_CMD) |=> rdata_out == 8'h00)
    else $error("command read not zero");

  // Reset and output copies
  a_swrst_keep: assert property (@(posedge clk_in) disable iff (!nrst_in)
    swrst |=> (ctrl_q == CTRL_RST) && (base_q == BASE_RST) && $stable(debug_q))
    else $error("soft reset values wrong");
  a_out_mirror: assert property (@(posedge clk_in) disable iff (!nrst_in)
    1'b1 |=> (base_out == $past(base_q))
      && ({2'h0, ctrl_out} == ($past(ctrl_q) & CTRL_MASK))
      && ({5'h00, debug_out} == ($past(debug_q) & DEBUG_MASK)))
    else $error("output copies lag wrong");
endmodule : rab_bank

// file: include/rab_pkg.sv
// Constants and carrier types for the register access bank
package rab_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;
  // Register index map inside the bank
  localparam logic [2:0] REG_BASE   = 3'h0;
  localparam logic [2:0] REG_SET    = 3'h1;
  localparam logic [2:0] REG_CLEAR  = 3'h2;
  localparam logic [2:0] REG_TOGGLE = 3'h3;
  localparam logic [2:0] REG_CTRL   = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam logic [2:0] REG_CMD    = 3'h6;
  localparam logic [2:0] REG_DEBUG  = 3'h7;
  // Field layouts: implemented bits per register, rest reserved
  localparam logic [7:0] CTRL_MASK   = 8'h3f;
  localparam logic [7:0] STATUS_MASK = 8'h0f;
  localparam logic [7:0] DEBUG_MASK  = 8'h07;
  localparam logic [7:0] CMD_MASK    = 8'h03;
  // Reset values
  localparam logic [7:0] BASE_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST  = 8'h01;
  localparam logic [7:0] DEBUG_RST = 8'h00;
  // Command bit positions (write-only)
  localparam int unsigned CMD_SWRST_BIT = 0;
  localparam int unsigned CMD_PULSE_BIT = 1;

  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [2:0]       addr;
    logic [7:0]       wdata;
  } rab_req_t;

  typedef enum logic [1:0] {
    RAB_OP_NONE   = 2'h0,
    RAB_OP_SET    = 2'h1,
    RAB_OP_CLEAR  = 2'h3,
    RAB_OP_TOGGLE = 2'h2
  } rab_op_t;
endpackage : rab_pkg

// file: logic/rab_pair_reg.sv
// Base register with set, clear and toggle companions
`timescale 1ns/1ps
module rab_pair_reg (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              swrst_in,
  input  wire logic              wr_in,
  input  wire rab_pkg::rab_op_t  op_in,
  input  wire logic [7:0]        wdata_in,
  output logic [7:0]             value_out
);
  import rab_pkg::*;

  logic [7:0] next_value;

  always_comb begin
    next_value = value_out;
    if (wr_in) begin
      unique case (op_in)
        RAB_OP_NONE: next_value = wdata_in;
        RAB_OP_SET:  next_value = value_out | wdata_in;
        RAB_OP_CLEAR:  next_value = value_out & ~wdata_in;
        RAB_OP_TOGGLE: next_value = value_out ^ wdata_in;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      value_out <= BASE_RST;
    end else if (swrst_in) begin
      value_out <= BASE_RST;
    end else begin
      value_out <= next_value;
    end
  end
endmodule : rab_pair_reg

// file: test/rab_bank_tb.sv
// Self-checking bench for the register access bank
`timescale 1ns/1ps
module rab_bank_tb;
  import rab_pkg::*;
  typedef struct {
    logic [2:0] wa;
    logic [7:0] wd;
    logic [2:0] ra;
    logic [7:0] e;
  } rab_row_t;
  logic       clk_in;
  logic       nrst_in;
  rab_req_t   req;
  logic [3:0] status_in;
  logic [7:0] rdata_out;
  logic       rvalid_out;
  logic [7:0] base_out;
  logic [5:0] ctrl_out;
  logic [2:0] debug_out;
  logic       pulse_out;
  int         num_errors;
  int         samples_checked;
  int         cnt;
  // Write one register, read one back; reserved bits always written as zero
  rab_row_t rows[9] = '{
    '{REG_BASE, 8'ha5, REG_BASE, 8'ha5},
    '{REG_SET, 8'h50, REG_SET, 8'hf5},
    '{REG_CLEAR, 8'h81, REG_BASE, 8'h74},
    '{REG_TOGGLE, 8'h0f, REG_TOGGLE, 8'h7b},
    '{REG_CLEAR, 8'h00, REG_CLEAR, 8'h7b},
    '{REG_CTRL, 8'h3e, REG_CTRL, 8'h3e},
    '{REG_DEBUG, 8'h05, REG_DEBUG, 8'h05},
    '{REG_STATUS, 8'h05, REG_STATUS, 8'h0a},
    '{REG_SET, 8'h00, REG_SET, 8'h7b}
  };
  rab_bank dut_u (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .req_in     (req),
    .status_in  (status_in),
    .rdata_out  (rdata_out),
    .rvalid_out (rvalid_out),
    .base_out   (base_out),
    .ctrl_out   (ctrl_out),
    .debug_out  (debug_out),
    .pulse_out  (pulse_out)
  );
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Request held from one falling edge to the next; caller overwrites it
  task automatic xfer(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
    req.wr = w;
    req.rd = r;
    req.addr = a;
    req.wdata = d;
    @(negedge clk_in);
    if (r) begin
      chk({7'h00, rvalid_out}, 8'h01);
      chk(rdata_out, e);
    end else begin
      chk({7'h00, rvalid_out}, 8'h00);
      chk(rdata_out, 8'h00);
    end
  endtask : xfer
  task automatic summarize();
    $display("Checked %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
  initial begin
    nrst_in = 1'b0;
    req = '0;
    status_in = 4'ha;
    num_errors = 0;
    samples_checked = 0;
    repeat (6) @(negedge clk_in);
    chk({2'b00, ctrl_out}, 8'h01);
    chk(base_out, BASE_RST);
    nrst_in = 1'b1;
    xfer(0, 1, REG_CTRL, 8'h00, CTRL_RST);
    xfer(0, 1, REG_DEBUG, 8'h00, DEBUG_RST);
    $display("Test reset done");
    foreach (rows[i]) begin
      xfer(1, 0, rows[i].wa, rows[i].wd, 8'h00);
      xfer(0, 1, rows[i].ra, 8'h00, rows[i].e);
    end
    xfer(0, 0, 3'h0, 8'h00, 8'h00);
    chk(base_out, 8'h7b);
    chk({2'b00, ctrl_out}, 8'h3e);
    chk({5'h00, debug_out}, 8'h05);
    $display("Test rows done");
    xfer(1, 0, REG_SET, 8'h84, 8'h00);
    xfer(1, 0, REG_TOGGLE, 8'h0c, 8'h00);
    xfer(1, 0, REG_CLEAR, 8'h02, 8'h00);
    xfer(0, 1, REG_TOGGLE, 8'h00, 8'hf1);
    $display("Test back to back done");
    xfer(1, 0, REG_CMD, 8'h02, 8'h00);
    cnt = 0;
    for (int i = 0; i < 4; i++) begin
      cnt += int'(pulse_out === 1'b1);
      xfer(0, 0, 3'h0, 8'h00, 8'h00);
    end
    chk(cnt[7:0], 8'h01);
    $display("Test command pulse done");
    xfer(1, 0, REG_CMD, 8'h01, 8'h00);
    xfer(0, 1, REG_BASE, 8'h00, BASE_RST);
    xfer(0, 1, REG_CTRL, 8'h00, CTRL_RST);
    xfer(0, 1, REG_DEBUG, 8'h00, 8'h05);
    chk(base_out, BASE_RST);
    $display("Test soft reset done");
    xfer(1, 1, REG_BASE, 8'h11, 8'h00);
    xfer(0, 1, REG_SET, 8'h00, 8'h11);
    xfer(0, 1, REG_CLEAR, 8'h00, 8'h11);
    xfer(0, 0, 3'h0, 8'h00, 8'h00);
    $display("Test read with write done");
    status_in = 4'h5;
    xfer(0, 0, 3'h0, 8'h00, 8'h00);
    xfer(0, 0, 3'h0, 8'h00, 8'h00);
    xfer(1, 1, REG_STATUS, 8'h03, 8'h05);
    xfer(0, 1, REG_STATUS, 8'h00, 8'h05);
    $display("Test status pins done");
    nrst_in = 1'b0;
    @(negedge clk_in);
    chk({5'h00, debug_out}, 8'h00);
    chk(base_out, BASE_RST);
    nrst_in = 1'b1;
    xfer(0, 1, REG_DEBUG, 8'h00, DEBUG_RST);
    xfer(0, 1, REG_CTRL, 8'h00, CTRL_RST);
    $display("Test second reset done");
    summarize();
  end
endmodule : rab_bank_tb
